/* core/follow_pkg.sv */
package follow_pkg;
  localparam int POS_W = 32;
  localparam int VEL_W = 32;
  localparam int AXIS_W = 2;
  // Sample divider: 25 MHz clock, 2 ms position loop
  localparam int CLK_HZ = 25000000;
  localparam int SAMPLE_US = 2000;
  localparam int SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;
  localparam logic [31:0] PCP_REF = 32'h00000000;
  localparam logic [POS_W-1:0] HOME_RST = 32'h00000000;
  // Parameter register indices for the trigger capture
  localparam logic [7:0] CAPT_REG_AX1 = 8'he2;
  localparam logic [7:0] CAPT_REG_AX2 = 8'hea;
  // Register port offsets
  localparam logic [3:0] A_ACT_POS = 4'h0;
  localparam logic [3:0] A_CMD_POS = 4'h1;
  localparam logic [3:0] A_PCP = 4'h2;
  localparam logic [3:0] A_ACT_VEL = 4'h3;
  localparam logic [3:0] A_CMD_VEL = 4'h4;
  localparam logic [3:0] A_USER_SEL = 4'h5;
  localparam logic [3:0] A_STATUS = 4'h6;
  localparam logic [3:0] A_CAPT = 4'h7;
  localparam logic [3:0] A_HOME_VAL = 4'h8;
  localparam logic [3:0] A_CAPT_IDX = 4'h9;
  // Status bit positions
  localparam int ST_MOVING = 0;
  localparam int ST_FOLLOWING = 1;
  localparam int ST_POS_VALID = 2;
  localparam int ST_ERROR = 3;
  localparam int ST_PROG = 4;
  localparam int ST_SEL_PCP = 5;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_PROG = 3'b001,
    M_JOG = 3'b010,
    M_HOME = 3'b011,
    M_VEL = 3'b100
  } move_t;

  typedef struct packed {
    logic follow_req;
    logic abort;
    logic home;
    logic prog_start;
    logic jog;
    logic move_vel;
    logic set_pos;
    logic sel_pcp;
    logic sel_other;
    logic [POS_W-1:0] set_val;
  } cmd_t;

  typedef struct packed {
    logic signed [VEL_W-1:0] int_vel;
    logic int_done;
    logic home_found;
    logic signed [VEL_W-1:0] master_vel;
    logic signed [POS_W-1:0] pos_err;
    logic trigger;
  } motion_in_t;
endpackage : follow_pkg

/* core/sample_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module sample_tick #(
  parameter int CYC = 50000
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);
  logic [31:0] cnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_r == 32'(CYC - 1)) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule : sample_tick
`default_nettype wire

/* core/follow_axis.sv */
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (R01) Program position moves by internal velocity only
// (R02) Actual velocity is internal plus master
// (R03) Commanded velocity from internal velocity alone
// (R04) Home/jog/velocity update program position unused
// (R05) Actual position sums internal and master
// (R06) Commanded position equals actual plus error
// (R07) Home refused while following, error returned
// (R08) Home loads home value, syncs program
// (R09) Set position loads value, syncs program
// (R10) Set position rejected while moving
// (R11) Program start: sync or zero program
// (R12) Incremental moves wrap at limits
// (R13) Abort ends any internal move
// (R14) User word may report program position
// (R15) Follow starts at trigger after enable
// (R16) Trigger captures commanded position per axis
// (R17) Position valid after home completes
// (R18) Program position wraps at 32 bits
// (R19) Master affects only actual values
// (R20) Axis driven by master plus internal
// (R21) Updates once per loop sample
module follow_axis
  import follow_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int AXIS_NUM = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire follow_pkg::cmd_t cmd,
  input wire follow_pkg::motion_in_t mot,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [31:0] drive_vel,
  output logic moving,
  output logic following,
  output logic pos_valid,
  output logic status_err
);
  import follow_pkg::*;

  typedef struct packed {
    move_t mode;
    logic follow_arm;
    logic following;
    logic pos_valid;
    logic err;
    logic sel_pcp;
    logic [POS_W-1:0] act_pos;
    logic [POS_W-1:0] pcp;
    logic [VEL_W-1:0] act_vel;
    logic [VEL_W-1:0] cmd_vel;
    logic [POS_W-1:0] capt;
    logic [POS_W-1:0] home_val;
    logic [31:0] rdata;
    logic [31:0] drive_vel;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic tick;

  sample_tick #(.CYC(SAMPLE_CYCLES)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  logic [POS_W-1:0] cmd_pos;
  logic internal;
  logic [VEL_W-1:0] ivel;
  logic [VEL_W-1:0] mvel;
  logic [7:0] capt_idx;

  assign cmd_pos = s_r.act_pos + mot.pos_err; // (R06)
  assign internal = (s_r.mode != M_IDLE);
  assign ivel = internal ? mot.int_vel : 32'h00000000;
  assign mvel = s_r.following ? mot.master_vel : 32'h00000000;
  assign capt_idx = (AXIS_NUM == 1) ? CAPT_REG_AX1 : CAPT_REG_AX2;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 32'h00000000;
    // Clear first so a same-cycle refusal wins
    if (wr) begin
      case (addr)
        A_HOME_VAL: s_nxt.home_val = wdata;
        A_STATUS: begin
          if (wdata[ST_ERROR]) begin
            s_nxt.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Host commands take effect at once; motion waits for the sample
    if (cmd.abort) begin
      s_nxt.mode = M_IDLE; // (R13)
    end else begin
      if (cmd.home) begin
        if (s_r.following) begin
          s_nxt.err = 1'b1; // (R07)
        end else begin
          s_nxt.mode = M_HOME;
          s_nxt.pos_valid = 1'b0;
        end
      end
      if (cmd.prog_start && s_r.mode == M_IDLE) begin
        s_nxt.mode = M_PROG;
        s_nxt.pcp = s_r.following ? PCP_REF : cmd_pos; // (R11)
      end
      if (cmd.jog && s_r.mode == M_IDLE) begin
        s_nxt.mode = M_JOG;
      end
      if (cmd.move_vel && s_r.mode == M_IDLE) begin
        s_nxt.mode = M_VEL;
      end
    end
    if (cmd.set_pos) begin
      if (internal) begin
        s_nxt.err = 1'b1; // (R10)
      end else begin
        s_nxt.act_pos = cmd.set_val; // (R09)
        s_nxt.pcp = cmd.set_val + mot.pos_err; // (R09)
      end
    end
    if (cmd.sel_pcp) begin
      s_nxt.sel_pcp = 1'b1; // (R14)
    end else if (cmd.sel_other) begin
      s_nxt.sel_pcp = 1'b0;
    end
    // Following arms on the bit, starts only at the trigger
    if (!cmd.follow_req) begin
      s_nxt.follow_arm = 1'b0;
      s_nxt.following = 1'b0;
    end else if (!s_r.follow_arm) begin
      s_nxt.follow_arm = 1'b1;
    end else if (!s_r.following && mot.trigger) begin
      s_nxt.following = 1'b1; // (R15)
      s_nxt.capt = cmd_pos; // (R16)
    end
    if (tick) begin
      // Sum wraps modulo 2^32 (R12) (R18)
      case (s_r.mode)
        M_PROG: begin
          s_nxt.pcp = s_r.pcp + ivel; // (R01)
          s_nxt.cmd_vel = ivel; // (R03)
        end
        M_JOG, M_VEL, M_HOME: begin
          s_nxt.pcp = s_r.pcp + ivel; // (R04)
          s_nxt.cmd_vel = ivel; // (R04)
        end
        default: begin
          s_nxt.cmd_vel = 32'h00000000; // (R19)
        end
      endcase
      // Keeps a same-cycle set-position load
      s_nxt.act_pos = s_nxt.act_pos + ivel + mvel; // (R05) (R19) (R21)
      s_nxt.act_vel = ivel + mvel; // (R02)
      s_nxt.drive_vel = ivel + mvel; // (R20)
      if (internal && mot.int_done) begin
        s_nxt.mode = M_IDLE;
      end
      if (s_r.mode == M_HOME && mot.home_found && !s_r.following) begin
        s_nxt.act_pos = s_r.home_val; // (R08)
        s_nxt.pcp = s_r.home_val + mot.pos_err; // (R08)
        s_nxt.pos_valid = 1'b1; // (R17)
        s_nxt.mode = M_IDLE;
      end
    end
    if (rd) begin
      case (addr)
        A_ACT_POS: s_nxt.rdata = s_r.act_pos;
        A_CMD_POS: s_nxt.rdata = cmd_pos; // (R06)
        A_PCP: s_nxt.rdata = s_r.pcp;
        A_ACT_VEL: s_nxt.rdata = s_r.act_vel;
        A_CMD_VEL: s_nxt.rdata = s_r.cmd_vel;
        A_USER_SEL: s_nxt.rdata = s_r.sel_pcp ? s_r.pcp : cmd_pos; // (R14)
        A_STATUS: begin
          s_nxt.rdata = {26'h0000000, s_r.sel_pcp,
            (s_r.mode == M_PROG), s_r.err, s_r.pos_valid,
            s_r.following, internal};
        end
        A_CAPT: s_nxt.rdata = s_r.capt;
        A_HOME_VAL: s_nxt.rdata = s_r.home_val;
        A_CAPT_IDX: s_nxt.rdata = {24'h000000, capt_idx};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{mode: M_IDLE, home_val: HOME_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h00000000;
      drive_vel <= 32'h00000000;
      moving <= 1'b0;
      following <= 1'b0;
      pos_valid <= 1'b0;
      status_err <= 1'b0;
    end else begin
      rdata <= s_nxt.rdata;
      drive_vel <= s_nxt.drive_vel;
      moving <= (s_nxt.mode != M_IDLE);
      following <= s_nxt.following;
      pos_valid <= s_nxt.pos_valid;
      status_err <= s_nxt.err;
    end
  end
endmodule : follow_axis
`default_nettype wire

/* sim/follow_axis_props.sv */
`timescale 1ns/100ps
`default_nettype none
module follow_axis_props #(
  parameter int AXIS_NUM = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire follow_pkg::cmd_t cmd,
  input wire follow_pkg::motion_in_t mot,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic moving,
  input wire logic following,
  input wire logic status_err
);
  import follow_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  localparam logic [7:0] IDX = (AXIS_NUM == 1) ? CAPT_REG_AX1 : CAPT_REG_AX2;
  chk_home_refused: assert property (
    cmd.home && !cmd.abort && following |=> status_err)
    else $error("home not refused");
  chk_setpos_busy: assert property (
    cmd.set_pos && moving |=> status_err) else $error("set_pos not refused");
  chk_abort_halts: assert property (
    cmd.abort && !following |=> !moving) else $error("abort left motion");
  chk_follow_start: assert property (
    $rose(following) |-> $past(mot.trigger) && $past(cmd.follow_req))
    else $error("following without trigger");
  chk_capt_index: assert property (
    rd && addr == A_CAPT_IDX |=> rdata == {24'h0, IDX})
    else $error("capture index wrong");
  chk_setpos_load: assert property (
    (cmd.set_pos && !moving && !following && mot.int_vel == 0
    ##2 rd && addr == A_ACT_POS)
    |=> rdata == $past(cmd.set_val, 3)) else $error("set_pos not loaded");
  chk_status_mirror: assert property (
    rd && addr == A_STATUS |=> rdata[ST_FOLLOWING] == $past(following))
    else $error("status bit mismatch");
  chk_err_clear: assert property (
    wr && addr == A_STATUS && wdata[ST_ERROR] && !cmd.home && !cmd.set_pos
    |=> !status_err) else $error("error not cleared");
  cover property ($rose(following));
  cover property (cmd.home && following);
  cover property (cmd.set_pos && moving);
endmodule : follow_axis_props
bind follow_axis follow_axis_props #(.AXIS_NUM(AXIS_NUM)) props_i (
  .clk(clk), .arst_n(arst_n), .cmd(cmd), .mot(mot), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .moving(moving),
  .following(following), .status_err(status_err));
`default_nettype wire

/* sim/host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk,
  output var follow_pkg::cmd_t cmd
);
  import follow_pkg::*;
  initial cmd = '0;
  // Enable is a level; the trigger decides when following starts
  task automatic follow(input logic on);
    @(posedge clk);
    cmd.follow_req <= on;
  endtask : follow
  // One-cycle command pulse, enable level kept
  task automatic pulse(input logic [7:0] b, input logic [31:0] v);
    @(posedge clk);
    cmd <= {cmd.follow_req, b, v};
    @(posedge clk);
    cmd <= {cmd.follow_req, 8'h00, 32'h0};
  endtask : pulse
endmodule : host_model
`default_nettype wire

/* sim/follower_program_position_tracking_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module follower_program_position_tracking_tb_top;
  import follow_pkg::*;
  localparam logic [7:0] ABORT = 8'h80, HOME = 8'h40, PROG = 8'h20;
  localparam logic [7:0] SETP = 8'h04, SELP = 8'h02;
  localparam logic [7:0] JOG = 8'h10, VEL = 8'h08;
  typedef struct {logic [3:0] a; logic [31:0] e;} row_t;
  row_t rows [5] = '{'{A_ACT_POS, 32'h0}, '{A_PCP, 32'h0}, '{A_CMD_VEL, 32'h0},
    '{A_CAPT_IDX, {24'h0, CAPT_REG_AX1}}, '{A_HOME_VAL, HOME_RST}};
  logic clk = 0, arst_n = 0, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, drive_vel;
  logic [31:0] snap, pcp0;
  logic moving, following, pos_valid, status_err;
  motion_in_t mot = '0;
  cmd_t cmd;
  int failures = 0, compares = 0, cyc = 0;
  host_model host (.clk(clk), .cmd(cmd));
  follow_axis #(.SAMPLE_CYCLES(4), .AXIS_NUM(1)) uut (.clk(clk),
    .arst_n(arst_n), .cmd(cmd), .mot(mot), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .drive_vel(drive_vel),
    .moving(moving), .following(following), .pos_valid(pos_valid),
    .status_err(status_err));
  initial forever #20 clk = ~clk;
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Generous ceiling; the run needs under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
    input string n, input logic [31:0] m = '1);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(n, rdata & m, e & m);
  endtask : rdc
  task automatic rds(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask : rds
  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask : wrt
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1;
    #1 chk("pos_valid", 32'(pos_valid), 0);
    foreach (rows[i]) rdc(rows[i].a, rows[i].e, "reg");
    rdc(A_STATUS, 32'h0, "status");
    @(posedge clk) mot.pos_err <= 5;
    host.pulse(SETP, 32'h7ffffff0);
    rdc(A_ACT_POS, 32'h7ffffff0, "act_pos");
    rdc(A_PCP, 32'h7ffffff5, "pcp");
    rdc(A_CMD_POS, 32'h7ffffff5, "cmd_pos");
    host.pulse(SELP, 32'h0);
    rdc(A_USER_SEL, 32'h7ffffff5, "user_sel");
    host.pulse(PROG, 32'h0);
    rdc(A_PCP, 32'h7ffffff5, "pcp");
    @(posedge clk) mot.int_vel <= 7;
    repeat (16) @(posedge clk);
    rdc(A_CMD_VEL, 32'h7, "cmd_vel");
    rdc(A_PCP, 32'h80000000, "pcp_wrap", 32'h80000000);
    chk("moving", 32'(moving), 1);
    host.pulse(SETP, 32'h0);
    #1 chk("status_err", 32'(status_err), 1);
    host.pulse(ABORT, 32'h0);
    #1 chk("moving", 32'(moving), 0);
    @(posedge clk) mot.int_vel <= 0;
    wrt(A_STATUS, 32'h8);
    #1 chk("status_err", 32'(status_err), 0);
    host.pulse(SETP, 32'h100);
    host.follow(1);
    repeat (3) @(posedge clk);
    @(posedge clk) mot.trigger <= 1;
    for (int i = 0; i < 20 && following !== 1'b1; i++) @(posedge clk);
    #1 chk("following", 32'(following), 1);
    rdc(A_CAPT, 32'h105, "capt");
    host.pulse(HOME, 32'h0);
    #1 chk("status_err", 32'(status_err), 1);
    wrt(A_STATUS, 32'h8);
    host.pulse(PROG, 32'h0);
    rdc(A_PCP, 32'h0, "pcp");
    @(posedge clk) mot.int_vel <= 7;
    @(posedge clk) mot.master_vel <= 3;
    repeat (16) @(posedge clk);
    rdc(A_ACT_VEL, 32'ha, "act_vel");
    rdc(A_CMD_VEL, 32'h7, "cmd_vel");
    chk("drive_vel", drive_vel, 32'ha);
    // Reads eight cycles apart span exactly two samples
    @(posedge clk) mot.int_vel <= 0;
    rds(A_ACT_POS, snap);
    rds(A_PCP, pcp0);
    repeat (4) @(posedge clk);
    rdc(A_ACT_POS, snap + 6, "follow_act_pos");
    rdc(A_PCP, pcp0, "follow_pcp");
    rdc(A_CMD_VEL, 32'h0, "follow_cmd_vel");
    host.pulse(ABORT, 32'h0);
    host.pulse(JOG, 32'h0);
    @(posedge clk) mot.int_vel <= 2;
    rds(A_ACT_POS, snap);
    rds(A_PCP, pcp0);
    repeat (4) @(posedge clk);
    rdc(A_ACT_POS, snap + 10, "jog_act_pos");
    rdc(A_PCP, pcp0 + 4, "jog_pcp");
    rdc(A_CMD_VEL, 32'h2, "jog_cmd_vel");
    host.pulse(ABORT, 32'h0);
    host.follow(0);
    wrt(A_HOME_VAL, 32'h1234);
    host.pulse(HOME, 32'h0);
    #1 chk("moving", 32'(moving), 1);
    @(posedge clk) mot.home_found <= 1;
    repeat (5) @(posedge clk);
    #1 chk("pos_valid", 32'(pos_valid), 1);
    rdc(A_ACT_POS, 32'h1234, "home_act_pos");
    rdc(A_PCP, 32'h1239, "home_pcp");
    host.pulse(VEL, 32'h0);
    @(posedge clk) mot.int_vel <= 4;
    repeat (5) @(posedge clk);
    rdc(A_CMD_VEL, 32'h4, "vel_cmd_vel");
    close_out();
  end
endmodule : follower_program_position_tracking_tb_top
`default_nettype wire
